/* rtl/tlr_pkg.sv */
// shared constants for the table read reply / indirect write block
package tlr_pkg;
    // record codes on the lookaside link
    localparam logic [7:0] CODE_TABLE_READ     = 8'hfe; // 254
    localparam logic [7:0] CODE_INDIRECT_WRITE = 8'hfd; // 253
    // bytes after the code byte, per request kind
    localparam logic [4:0] READ_BODY_BYTES     = 5'h03;
    localparam logic [4:0] WRITE_BODY_BYTES    = 5'h1a; // 26
    // bytes per reply record, code byte included
    localparam logic [2:0] READ_REPLY_BYTES    = 3'h7;
    localparam logic [2:0] WRITE_REPLY_BYTES   = 3'h4;
    // address word field positions
    localparam int ADDR_FMT_BIT   = 31;
    localparam int ADDR_VALID_BIT = 30;
    localparam int ADDR_RSV_HI    = 29;
    localparam int ADDR_RSV_LO    = 27;
    localparam int REGION_HI      = 26;
    localparam int REGION_LO      = 25;
    localparam int LOC_RSV_HI     = 24;
    localparam int LOC_RSV_LO     = 23;
    // region select patterns
    localparam logic [1:0] REGION_REG    = 2'h0;
    localparam logic [1:0] REGION_RULE   = 2'h1;
    localparam logic [1:0] REGION_ASSOC  = 2'h2;
    localparam logic [1:0] REGION_UNUSED = 2'h3;
    // status byte values
    localparam logic [7:0] STATUS_OK  = 8'h00;
    localparam logic [7:0] STATUS_ERR = 8'h01;
    // parser / reply states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_BODY = 5'b00010,
        ST_LOOK = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_SEND = 5'b10000
    } tlr_state_type;
endpackage : tlr_pkg

/* rtl/tlr_code_table.sv */
`timescale 1ns/1ns
// code lookup table storage, registered read data
module tlr_code_table #(
    parameter int AW = 8,
    parameter int DW = 19
) (
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data_q
);
    logic [DW-1:0] mem [0:(1<<AW)-1]; // entry storage, not reset

    // write port, filled by the table write path outside this block
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port: data valid the cycle after rd_en
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule : tlr_code_table

/* rtl/tlr_top.sv */
`timescale 1ns/1ns
// Function
// R01: read reply: code 254, status, entry
// R02: reply echoes request sequence tag
// R03: read status upper zero, bit0 error
// R04: next record code follows payload
// R05: indirect write is 27-byte code 253; code takes 26 body bytes after the code byte, 27 in all
// R06: tag, address, data/X, mask/Y order
// R07: address word: format, valid, zeros, location
// R08: format zero means data plus mask
// R09: format one means X and Y
// R10: associated array: 32 or 64 bit
// R11: host keeps format zero for registers
// R12: entry valid bit stored with entry
// R13: bits 26:25 choose target region
// R14: host keeps location bits 24:23 zero
// R15: mask ignored for register, associated writes
// R16: write reply: code 253, tag, status
// R17: host read request carries table address
// R18: bad region or reserved bits: error
module tlr_top
    import tlr_pkg::*;
#(
    parameter int TAW = 8,  // code table address width
    parameter int TDW = 19  // code table entry width
) (
    input  wire logic           clk_sys,
    input  wire logic           srst,
    input  wire logic           rx_valid,
    input  wire logic [7:0]     rx_byte,
    output logic                rx_ready_q,
    output logic                tx_valid_q,
    output logic [7:0]          tx_byte_q,
    output logic                tx_last_q,
    input  wire logic           tx_ready,
    input  wire logic           tbl_wr_en,
    input  wire logic [TAW-1:0] tbl_wr_addr,
    input  wire logic [TDW-1:0] tbl_wr_data,
    output logic                wr_valid_q,
    output logic [1:0]          wr_region_q,
    output logic [26:0]         wr_loc_addr_q,
    output logic                wr_entry_valid_q,
    output logic                wr_xy_q,
    output logic                wr_size64_q,
    output logic [79:0]         wr_data_q,
    output logic [79:0]         wr_mask_q
);
    import tlr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations
    tlr_state_type  state_q;     // parser state
    tlr_state_type  state_d;     // next parser state
    logic           is_write_q;  // current request is an indirect write
    logic [4:0]     cnt_q;       // body bytes taken so far
    logic [4:0]     need_q;      // body bytes expected
    logic [199:0]   body_q;      // body bytes so far, newest lowest
    logic [207:0]   body_full;   // body including byte being taken
    logic [55:0]    reply_q;     // reply bytes, next byte highest
    logic [2:0]     left_q;      // reply bytes not yet presented
    logic [TDW-1:0] tbl_rd_data; // looked-up entry
    logic           take;        // request byte accepted
    logic           body_done;   // last body byte accepted
    logic           advance;     // output register may load
    logic           exec_write;  // write request complete this cycle
    logic [31:0]    addr_w;      // address word of write request
    logic [1:0]     region_w;    // region select of write request
    logic           bad_w;       // write request refused

    assign take      = rx_valid && rx_ready_q;
    assign body_done = take && state_q == ST_BODY
                       && cnt_q == need_q - 5'h01;
    assign advance   = !tx_valid_q || tx_ready;
    assign body_full = {body_q[199:0], rx_byte};
    assign exec_write = body_done && is_write_q;
    // R06 field order
    assign addr_w    = body_full[191:160];
    assign region_w  = addr_w[REGION_HI:REGION_LO];
    // R18 refuse bad writes
    assign bad_w = region_w == REGION_UNUSED
                   || addr_w[ADDR_RSV_HI:ADDR_RSV_LO] != 3'h0
                   || addr_w[LOC_RSV_HI:LOC_RSV_LO] != 2'h0;

    ////////////////////////////////////////////////////////////////////
    // code table
    tlr_code_table #(
        .AW (TAW),
        .DW (TDW)
    ) u_table (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .wr_en     (tbl_wr_en),
        .wr_addr   (tbl_wr_addr),
        .wr_data   (tbl_wr_data),
        .rd_en     (state_q == ST_LOOK),
        .rd_addr   (body_q[TAW-1:0]),
        .rd_data_q (tbl_rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // R05 recognise request codes, others are skipped
                if (take && (rx_byte == CODE_TABLE_READ
                             || rx_byte == CODE_INDIRECT_WRITE)) begin
                    state_d = ST_BODY;
                end
            end
            ST_BODY: begin
                if (body_done) begin
                    state_d = is_write_q ? ST_SEND : ST_LOOK;
                end
            end
            ST_LOOK: state_d = ST_WAIT;
            ST_WAIT: state_d = ST_SEND;
            ST_SEND: begin
                if (advance && left_q <= 3'h1) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // state register and request ready; ready only while parsing
    // so a busy reply stalls the link core instead of losing bytes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            rx_ready_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            rx_ready_q <= state_d == ST_IDLE || state_d == ST_BODY;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // body collection
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            is_write_q <= 1'b0;
            cnt_q      <= 5'h00;
            need_q     <= READ_BODY_BYTES;
            body_q     <= '0;
        end else if (take && state_q == ST_IDLE) begin
            is_write_q <= rx_byte == CODE_INDIRECT_WRITE;
            need_q     <= rx_byte == CODE_INDIRECT_WRITE
                          ? WRITE_BODY_BYTES : READ_BODY_BYTES;
            cnt_q      <= 5'h00;
        end else if (take && state_q == ST_BODY) begin
            // top byte drops out: it is only needed while taken
            body_q <= body_full[199:0];
            cnt_q  <= cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write command outputs, one-cycle strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_valid_q       <= 1'b0;
            wr_region_q      <= REGION_REG;
            wr_loc_addr_q    <= '0;
            wr_entry_valid_q <= 1'b0;
            wr_xy_q          <= 1'b0;
            wr_size64_q      <= 1'b0;
            wr_data_q        <= '0;
            wr_mask_q        <= '0;
        end else if (exec_write) begin
            // R18 no storage change on error
            wr_valid_q       <= !bad_w;
            // R13 route by region bits
            wr_region_q      <= region_w;
            // R07 location field
            wr_loc_addr_q    <= addr_w[26:0];
            // R12 valid bit kept with entry
            wr_entry_valid_q <= addr_w[ADDR_VALID_BIT];
            // R08 R09 data/mask or X/Y
            wr_xy_q          <= addr_w[ADDR_FMT_BIT]
                                && region_w == REGION_RULE;
            // R10 associated array size, lsb aligned
            wr_size64_q      <= addr_w[ADDR_FMT_BIT]
                                && region_w == REGION_ASSOC;
            if (region_w == REGION_ASSOC) begin
                wr_data_q <= addr_w[ADDR_FMT_BIT]
                             ? {16'h0000, body_full[143:80]}
                             : {48'h0000_0000_0000, body_full[111:80]};
            end else begin
                wr_data_q <= body_full[159:80];
            end
            // R15 mask dropped outside rule array
            wr_mask_q <= region_w == REGION_RULE ? body_full[79:0] : '0;
        end else begin
            wr_valid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reply builder and byte pump
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reply_q <= '0;
            left_q  <= 3'h0;
        end else if (exec_write) begin
            // R16 write reply; R02 tag echo
            reply_q <= {CODE_INDIRECT_WRITE, body_full[207:192],
                        bad_w ? STATUS_ERR : STATUS_OK, 24'h00_0000};
            left_q  <= WRITE_REPLY_BYTES;
        end else if (state_q == ST_WAIT) begin
            // R01 read reply; R03 status clear, lookup never fails
            reply_q <= {CODE_TABLE_READ, body_q[23:8], STATUS_OK,
                        5'h00, tbl_rd_data};
            left_q  <= READ_REPLY_BYTES;
        end else if (state_q == ST_SEND && advance && left_q != 3'h0) begin
            reply_q <= {reply_q[47:0], 8'h00};
            left_q  <= left_q - 3'h1;
        end
    end

    // output byte register; replies end at the payload with no trailer, so the byte
    // after a payload is the next reply's code
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_valid_q <= 1'b0;
            tx_byte_q  <= 8'h00;
            tx_last_q  <= 1'b0;
        end else if (advance) begin
            // R04 next code follows payload
            if (state_q == ST_SEND && left_q != 3'h0) begin
                tx_valid_q <= 1'b1;
                tx_byte_q  <= reply_q[55:48];
                tx_last_q  <= left_q == 3'h1;
            end else begin
                tx_valid_q <= 1'b0;
                tx_last_q  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    write_route_a: assert property ( // R13
        @(posedge clk_sys) disable iff (srst)
        exec_write && !bad_w |=> wr_valid_q
            && wr_region_q == $past(region_w))
        else $error("write routed to wrong region");

    mask_ignore_a: assert property ( // R15
        @(posedge clk_sys) disable iff (srst)
        wr_valid_q && wr_region_q != REGION_RULE |-> wr_mask_q == '0)
        else $error("mask passed outside rule array");

    format_xy_a: assert property ( // R09
        @(posedge clk_sys) disable iff (srst)
        exec_write && region_w == REGION_RULE
            |=> wr_xy_q == $past(addr_w[ADDR_FMT_BIT]))
        else $error("format select not honoured");

    assoc_size_a: assert property ( // R10
        @(posedge clk_sys) disable iff (srst)
        wr_valid_q && wr_region_q == REGION_ASSOC && !wr_size64_q
            |-> wr_data_q[79:32] == '0)
        else $error("32-bit write carries upper data");

    entry_valid_a: assert property ( // R12
        @(posedge clk_sys) disable iff (srst)
        exec_write |=> wr_entry_valid_q == $past(addr_w[ADDR_VALID_BIT]))
        else $error("entry valid bit lost");

    reserved_err_a: assert property ( // R18
        @(posedge clk_sys) disable iff (srst)
        exec_write && bad_w |=> !wr_valid_q && reply_q[31:24] == STATUS_ERR)
        else $error("bad write not refused");

    seq_echo_a: assert property ( // R02
        @(posedge clk_sys) disable iff (srst)
        exec_write |=> reply_q[47:32] == $past(body_full[207:192]))
        else $error("sequence tag not echoed");

    read_reply_a: assert property ( // R01
        @(posedge clk_sys) disable iff (srst)
        state_q == ST_LOOK |-> ##2 reply_q[55:48] == CODE_TABLE_READ
            && left_q == READ_REPLY_BYTES && reply_q[23:19] == 5'h00)
        else $error("read reply malformed");

    read_status_a: assert property ( // R03
        @(posedge clk_sys) disable iff (srst)
        state_q == ST_LOOK |-> ##2 reply_q[31:25] == 7'h00)
        else $error("read status upper bits set");

    last_byte_a: assert property ( // R04
        @(posedge clk_sys) disable iff (srst)
        tx_valid_q && tx_ready && tx_last_q |=> !tx_valid_q || !tx_last_q)
        else $error("reply end marker repeated");
endmodule : tlr_top

/* bench/tlr_host_model.sv */
`timescale 1ns/1ns
// host side of the link: feeds request bytes, drains reply bytes
module tlr_host_model (
    input  wire logic       clk_sys,
    input  wire logic       rx_ready_q,
    input  wire logic       tx_valid_q,
    input  wire logic [7:0] tx_byte_q,
    input  wire logic       tx_last_q,
    input  wire logic       slow,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_ready
);
    logic [7:0] send_q[$]; // request bytes still to go
    logic [8:0] rcv_q[$];  // reply bytes, last flag on top
    logic       taken;     // byte accepted at the last edge
    logic       phase;     // stall pattern
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
        tx_ready = 1'b0;
        taken    = 1'b0;
        phase    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // handshakes are sampled on the rising edge only
    always @(posedge clk_sys) begin
        taken <= rx_valid && rx_ready_q;
        if (tx_valid_q === 1'b1 && tx_ready) begin
            rcv_q.push_back({tx_last_q, tx_byte_q});
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // host frames records
    // a byte stands until taken; a released line toggles so stale
    // data can never look valid
    always @(negedge clk_sys) begin
        if (!rx_valid || taken) begin
            if (send_q.size() > 0) begin
                rx_valid <= 1'b1;
                rx_byte  <= send_q.pop_front();
            end else begin
                rx_valid <= 1'b0;
                rx_byte  <= ~rx_byte;
            end
        end
        phase    <= ~phase;
        tx_ready <= slow ? phase : 1'b1;
    end
endmodule : tlr_host_model

/* bench/tlr_top_tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tlr_top_tb_top;
    import tlr_pkg::*;
    logic        clk_sys, srst, slow, rx_valid, tx_ready, tbl_wr_en;
    logic [7:0]  rx_byte, tx_byte_q, tbl_wr_addr;
    logic [18:0] tbl_wr_data;
    logic        rx_ready_q, tx_valid_q, tx_last_q, wr_valid_q;
    logic        wr_entry_valid_q, wr_xy_q, wr_size64_q;
    logic [1:0]  wr_region_q;
    logic [26:0] wr_loc_addr_q;
    logic [79:0] wr_data_q, wr_mask_q;
    int          fails, checked, pulses;
    // address words: two rule, two assoc, one register, then three bad ones
    logic [31:0] aws[8] = '{32'h4200_0123, 32'h8200_0456, 32'h0400_0010,
        32'hc400_0020, 32'h0000_0040, 32'h0600_0001, 32'h0280_0000,
        32'h0a00_0000};
    tlr_top i_tlr_top (.clk_sys, .srst, .rx_valid, .rx_byte, .rx_ready_q,
        .tx_valid_q, .tx_byte_q, .tx_last_q, .tx_ready, .tbl_wr_en,
        .tbl_wr_addr, .tbl_wr_data, .wr_valid_q, .wr_region_q,
        .wr_loc_addr_q, .wr_entry_valid_q, .wr_xy_q, .wr_size64_q,
        .wr_data_q, .wr_mask_q);
    tlr_host_model i_tlr_host_model (.clk_sys, .rx_ready_q, .tx_valid_q,
        .tx_byte_q, .tx_last_q, .slow, .rx_valid, .rx_byte, .tx_ready);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // storage write pulses seen
    always @(posedge clk_sys) if (wr_valid_q === 1'b1) pulses++;
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // wait, bounded, for a whole reply record and compare it
    task automatic exp_rec(input logic [7:0] e[$]);
        logic [8:0] got;
        int         n;
        n = 0;
        while (i_tlr_host_model.rcv_q.size() < e.size() && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        foreach (e[k]) begin
            got = 9'bx;
            if (i_tlr_host_model.rcv_q.size() > 0)
                got = i_tlr_host_model.rcv_q.pop_front();
            `CHK("reply byte", {k == e.size() - 1, e[k]}, got)
        end
    endtask : exp_rec
    task automatic push_read(input logic [15:0] tag, input logic [7:0] a);
        logic [31:0] r;
        r = {CODE_TABLE_READ, tag, a};
        for (int k = 3; k >= 0; k--) begin
            i_tlr_host_model.send_q.push_back(r[k*8+:8]);
        end
    endtask : push_read
    task automatic exp_read(input logic [15:0] tag, input logic [18:0] v);
        exp_rec('{CODE_TABLE_READ, tag[15:8], tag[7:0], STATUS_OK,
            {5'h00, v[18:16]}, v[15:8], v[7:0]});
    endtask : exp_read
    // one write record, its reply, then the storage outputs
    task automatic run_write(input logic [15:0] tag, input logic [31:0] aw,
        input logic [79:0] d, input logic [79:0] m);
        logic [207:0] r;
        logic [79:0]  ed;
        logic         err;
        int           p0;
        logic [1:0]   rg;
        rg  = aw[26:25];
        r   = {tag, aw, d, m};
        err = aw[26:25] == REGION_UNUSED || aw[29:27] != 0 || aw[24:23] != 0;
        p0  = pulses;
        i_tlr_host_model.send_q.push_back(CODE_INDIRECT_WRITE);
        for (int k = 25; k >= 0; k--) begin
            i_tlr_host_model.send_q.push_back(r[k*8+:8]);
        end
        exp_rec('{CODE_INDIRECT_WRITE, tag[15:8], tag[7:0],
            err ? STATUS_ERR : STATUS_OK});
        `CHK("pulse count", err ? p0 : p0 + 1, pulses)
        if (!err) begin
            ed = aw[31] ? {16'h0000, d[63:0]} : {48'h0, d[31:0]};
            if (aw[26:25] != REGION_ASSOC) ed = d;
            `CHK("region", aw[26:25], wr_region_q)
            `CHK("location", aw[26:0], wr_loc_addr_q)
            `CHK("entry valid", aw[30], wr_entry_valid_q)
            `CHK("xy form", aw[31] && rg == REGION_RULE, wr_xy_q)
            `CHK("size64", aw[31] && rg == REGION_ASSOC, wr_size64_q)
            `CHK("data", ed, wr_data_q)
            `CHK("mask", rg == REGION_RULE ? m : 80'h0, wr_mask_q)
        end
    endtask : run_write
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end
    initial begin
        {fails, checked, pulses} = '0;
        {srst, slow, tbl_wr_en} = 3'b100;
        tbl_wr_addr = 8'h00;
        tbl_wr_data = 19'h0_0000;
        repeat (3) @(negedge clk_sys);
        `CHK("ready in reset", 1'b0, rx_ready_q)
        srst = 1'b0;
        // fill two table entries at the address extremes
        tbl_wr_en = 1'b1;
        tbl_wr_data = 19'h7_ffff;
        @(negedge clk_sys);
        tbl_wr_addr = 8'hff;
        tbl_wr_data = 19'h5_a5a3;
        @(negedge clk_sys);
        tbl_wr_en = 1'b0;
        `CHK("ready when idle", 1'b1, rx_ready_q)
        // a stray code is dropped, then two reads back to back
        i_tlr_host_model.send_q.push_back(8'h11);
        push_read(16'hbeef, 8'hff);
        push_read(16'h0001, 8'h00);
        exp_read(16'hbeef, 19'h5_a5a3);
        exp_read(16'h0001, 19'h7_ffff);
        $display("test reads done");
        // every region, both formats, prompt then stalling host
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            for (int i = 0; i < 8; i++)
                run_write(16'(s * 16 + i), aws[i],
                    80'ha1b2_c3d4_e5f6_0718_293a ^ 80'(i),
                    80'h5f4e_3d2c_1b0a_9988_7766);
            push_read(16'h7e57, 8'hff);
            exp_read(16'h7e57, 19'h5_a5a3);
            $display("test writes pass %0d done", s);
        end
        tally_and_finish();
    end
endmodule : tlr_top_tb_top
